// [rtl/xmem_defines.svh]
// Purpose: constants for the extended memory address decoder
// Assumes: 32-bit byte addresses, 32-bit classic Wishbone register port
// Notes: types live in xmem_pkg
`ifndef XMEM_DEFINES_SVH
`define XMEM_DEFINES_SVH

// ***************************************************
// register offsets (byte addresses)
// ***************************************************
`define REG_CTRL 8'h00
`define REG_TOP 8'h04
`define REG_APER_BASE 8'h08
`define REG_APER_MASK 8'h0C
`define REG_MMIO_BASE 8'h10
`define REG_MMIO_MASK 8'h14
`define REG_USABLE 8'h18
`define REG_LAST 8'h1C

// ***************************************************
// control fields and reset values
// ***************************************************
`define CTRL_HOLE_BIT 0
`define CTRL_HIGH_MGMT_SEGMENT_BIT 1
`define CTRL_TOP_MGMT_SEGMENT_BIT 2
`define CTRL_GFX_BIT 3
`define CTRL_SIZE_LO 4
`define CTRL_SIZE_HI 5
`define CTRL_WMASK 32'h0000003F
`define CTRL_RST 32'h00000000
`define TOP_RST 32'h04000000
`define BASE_RST 32'hFFFFFFFF
`define MASK_RST 32'hFFFFFFFF
`define ZERO32 32'h00000000

// ***************************************************
// address map
// ***************************************************
`define ONE_MB 32'h00100000
`define TOP_MAX 32'h20000000
`define MB_MASK 32'hFFF00000
`define HOLE_TAG 12'h00F
`define HIGH_MGMT_SEGMENT_TAG 15'h7F6D
`define HIGH_MGMT_SEGMENT_DRAM_TAG 15'h0005
`define IOAPIC_TAG 12'hFEC
`define LAPIC_TAG 12'hFEE
`define GAP_LO 32'hFED00000
`define GAP_HI 32'hFFDFFFFF
`define BIOS_TAG 11'h7FF

`endif

// [rtl/xmem_pkg.sv]
// Purpose: shared types of the extended memory address decoder
// Assumes: nothing
// Notes: destination codes are also the dest select output encoding
package xmem_pkg;
	// destination of one decoded request
	typedef enum logic [1:0] {
		DEST_DRAM,
		DEST_GFX,
		DEST_HUB,
		DEST_ABORT
	} dest_t;
	// who issued the request
	typedef enum logic {
		SRC_CPU,
		SRC_HUB
	} src_t;
endpackage

// [rtl/decode_req_if.sv]
// Purpose: carrier between the router and the range classifier
// Assumes: single clock, classifier is purely combinational
// Notes: router drives address and windows, classifier answers hits
`timescale 1ns/10ps
interface decode_req_if;
	logic [31:0] addr; // request address
	logic [31:0] top_eff; // clipped top of main memory
	logic [31:0] top_mgmt_segment_base; // start of top segment
	logic [31:0] aper_base; // graphics aperture base
	logic [31:0] aper_mask; // graphics aperture mask
	logic [31:0] mmio_base; // graphics register base
	logic [31:0] mmio_mask; // graphics register mask
	logic hole_en;
	logic high_mgmt_segment_en;
	logic top_mgmt_segment_en;
	logic gfx_en;
	logic hit_main, hit_hole, hit_high_mgmt_segment, hit_top_mgmt_segment, hit_gfx, hit_apic, hit_gap, hit_bios;
	modport router (
		output addr, top_eff, top_mgmt_segment_base, aper_base, aper_mask, mmio_base, mmio_mask,
		output hole_en, high_mgmt_segment_en, top_mgmt_segment_en, gfx_en,
		input hit_main, hit_hole, hit_high_mgmt_segment, hit_top_mgmt_segment, hit_gfx, hit_apic, hit_gap, hit_bios
	);
	modport classifier (
		input addr, top_eff, top_mgmt_segment_base, aper_base, aper_mask, mmio_base, mmio_mask,
		input hole_en, high_mgmt_segment_en, top_mgmt_segment_en, gfx_en,
		output hit_main, hit_hole, hit_high_mgmt_segment, hit_top_mgmt_segment, hit_gfx, hit_apic, hit_gap, hit_bios
	);
endinterface

// [rtl/range_classifier.sv]
// Purpose: compares one address against every extended-area window
// Assumes: windows are stable while a request is classified
// Notes: hits may overlap; the router applies priority
`timescale 1ns/10ps
`include "xmem_defines.svh"
module range_classifier (
	decode_req_if.classifier dif
);
	// ***************************************************
	// window compares
	// ***************************************************
	// main memory from 1 MB up to the clipped top
	assign dif.hit_main = (dif.addr >= `ONE_MB) && (dif.addr < dif.top_eff);
	// fixed isa hole, only when enabled
	assign dif.hit_hole = dif.hole_en && (dif.addr[31:20] == `HOLE_TAG);
	// high segment transaction window
	assign dif.hit_high_mgmt_segment = dif.high_mgmt_segment_en && (dif.addr[31:17] == `HIGH_MGMT_SEGMENT_TAG);
	// top segment is the last slice below the top
	assign dif.hit_top_mgmt_segment = dif.top_mgmt_segment_en && (dif.addr >= dif.top_mgmt_segment_base) &&
		(dif.addr < dif.top_eff);
	// graphics aperture or register window, masked compare
	assign dif.hit_gfx = dif.gfx_en && (((dif.addr & dif.aper_mask) == dif.aper_base) ||
		((dif.addr & dif.mmio_mask) == dif.mmio_base));
	// both apic windows, never remapped
	assign dif.hit_apic = (dif.addr[31:20] == `IOAPIC_TAG) ||
		(dif.addr[31:20] == `LAPIC_TAG);
	// gap from the end of the io apic window up to the boot bios, taking in the local apic window
	assign dif.hit_gap = (dif.addr >= `GAP_LO) && (dif.addr <= `GAP_HI);
	// top 2 MB boot region
	assign dif.hit_bios = (dif.addr[31:21] == `BIOS_TAG);
endmodule

// [rtl/extended_memory_address_decoder.sv]
// Purpose: routes requests above 1 MB to DRAM, graphics unit or hub link
// Assumes: requests come from same-clock logic; one result per cycle
// Notes: registers reached over classic Wishbone, one-cycle answer
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "xmem_defines.svh"
module extended_memory_address_decoder (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// classic wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// request side
	input wire logic req_valid_in,
	input wire logic [31:0] req_addr_in,
	input wire logic req_smm_in,
	input wire logic req_src_in,
	input wire logic req_wb_in,
	input wire logic req_write_in,
	// decision side
	output logic dest_valid_out,
	output logic [1:0] dest_sel_out,
	output logic [31:0] dest_addr_out,
	output logic discard_write_out,
	output logic zero_read_out,
	output logic [3:0] apic_unit_out
);
	// ***************************************************
	// configuration state
	// ***************************************************
	logic [31:0] ctrl_ff; // enables and size select
	logic [31:0] top_ff; // programmed top of main memory
	logic [31:0] aper_base_ff; // graphics aperture base
	logic [31:0] aper_mask_ff; // graphics aperture mask
	logic [31:0] mmio_base_ff; // graphics register base
	logic [31:0] mmio_mask_ff; // graphics register mask
	logic ack_ff; // wishbone answer
	logic [31:0] rdat_ff; // wishbone read data
	logic [31:0] nxt_rdat; // read mux result
	logic wr_stb; // write accepted this cycle
	// decision registers
	logic valid_ff;
	xmem_pkg::dest_t dest_ff;
	xmem_pkg::dest_t nxt_dest;
	logic [31:0] daddr_ff;
	logic [31:0] nxt_daddr;
	logic discard_ff;
	logic zero_ff;
	logic [3:0] unit_ff;
	// derived windows
	logic [31:0] top_eff; // top clipped at its ceiling
	logic [31:0] top_mgmt_segment_size; // top segment size in bytes
	logic [31:0] top_mgmt_segment_base; // first top segment byte
	logic [31:0] usable_top; // memory left for the os
	logic is_cpu; // request from processor bus
	logic smm_ok; // may enter smm memory

	decode_req_if dif ();

	// ***************************************************
	// address windows
	// ***************************************************
	// top never exceeds the ceiling, and is kept to whole MB
	always_comb begin
		if ((top_ff & `MB_MASK) > `TOP_MAX) begin
			top_eff = `TOP_MAX;
		end else begin
			top_eff = top_ff & `MB_MASK;
		end
	end

	// size select doubles from 1 MB, reset picks 1 MB
	assign top_mgmt_segment_size = `ONE_MB << ctrl_ff[`CTRL_SIZE_HI:`CTRL_SIZE_LO];
	// segment placed just under the top; saturate on a tiny top
	assign top_mgmt_segment_base = (top_mgmt_segment_size > top_eff) ? `ZERO32 : (top_eff - top_mgmt_segment_size);
	// os sees memory less the segment when it is enabled
	assign usable_top = ctrl_ff[`CTRL_TOP_MGMT_SEGMENT_BIT] ? top_mgmt_segment_base : top_eff;

	// ***************************************************
	// classifier hookup
	// ***************************************************
	assign dif.addr = req_addr_in;
	assign dif.top_eff = top_eff;
	assign dif.top_mgmt_segment_base = top_mgmt_segment_base;
	assign dif.aper_base = aper_base_ff;
	assign dif.aper_mask = aper_mask_ff;
	assign dif.mmio_base = mmio_base_ff;
	assign dif.mmio_mask = mmio_mask_ff;
	assign dif.hole_en = ctrl_ff[`CTRL_HOLE_BIT];
	assign dif.high_mgmt_segment_en = ctrl_ff[`CTRL_HIGH_MGMT_SEGMENT_BIT];
	assign dif.top_mgmt_segment_en = ctrl_ff[`CTRL_TOP_MGMT_SEGMENT_BIT];
	assign dif.gfx_en = ctrl_ff[`CTRL_GFX_BIT];

	range_classifier u_classifier (
		.dif(dif.classifier)
	);

	// ***************************************************
	// routing decision
	// ***************************************************
	assign is_cpu = (req_src_in == xmem_pkg::SRC_CPU);
	// write-backs keep the cache coherent, so they pass too
	assign smm_ok = is_cpu && (req_smm_in || (req_wb_in && req_write_in));

	// priority: smm windows, hole, main, graphics, then hub
	always_comb begin
		nxt_dest = xmem_pkg::DEST_HUB;
		nxt_daddr = req_addr_in;
		if (dif.hit_high_mgmt_segment) begin
			if (smm_ok) begin
				// only the low 17 bits survive the remap
				nxt_dest = xmem_pkg::DEST_DRAM;
				nxt_daddr = {`HIGH_MGMT_SEGMENT_DRAM_TAG, req_addr_in[16:0]};
			end else begin
				// hub or plain cpu cycle: refused
				nxt_dest = xmem_pkg::DEST_ABORT;
			end
		end else if (dif.hit_top_mgmt_segment) begin
			if (smm_ok) begin
				nxt_dest = xmem_pkg::DEST_DRAM;
			end else begin
				nxt_dest = xmem_pkg::DEST_ABORT;
			end
		end else if (dif.hit_hole) begin
			// dram behind the hole stays unreachable
			nxt_dest = xmem_pkg::DEST_HUB;
		end else if (dif.hit_main) begin
			nxt_dest = xmem_pkg::DEST_DRAM;
		end else if (dif.hit_gfx && (req_addr_in >= top_eff)) begin
			nxt_dest = xmem_pkg::DEST_GFX;
		end else if (dif.hit_apic || dif.hit_gap || dif.hit_bios) begin
			// fixed windows, always the hub link
			nxt_dest = xmem_pkg::DEST_HUB;
		end else begin
			// compatibility area and pci space fall through to the hub
			nxt_dest = xmem_pkg::DEST_HUB;
		end
	end

	// ***************************************************
	// decision registers
	// ***************************************************
	// one result per request, one cycle after it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			valid_ff <= 1'b0;
			dest_ff <= xmem_pkg::DEST_HUB;
			daddr_ff <= `ZERO32;
		end else if (ce_in) begin
			valid_ff <= req_valid_in;
			if (req_valid_in) begin
				dest_ff <= nxt_dest;
				daddr_ff <= nxt_daddr;
			end
		end
	end

	// invalid space: writes dropped, reads answered with zero
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			discard_ff <= 1'b0;
			zero_ff <= 1'b0;
		end else if (ce_in) begin
			discard_ff <= req_valid_in && (nxt_dest == xmem_pkg::DEST_ABORT) &&
				req_write_in;
			zero_ff <= req_valid_in && (nxt_dest == xmem_pkg::DEST_ABORT) &&
				!req_write_in;
		end
	end

	// apic unit number rides on the fourth hex digit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			unit_ff <= 4'h0;
		end else if (ce_in && req_valid_in && dif.hit_apic) begin
			unit_ff <= req_addr_in[15:12];
		end
	end

	// ***************************************************
	// wishbone slave
	// ***************************************************
	assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && !ack_ff;

	// byte lanes honoured for every writable register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// answer one cycle after the strobe, then drop
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ack_ff <= 1'b0;
		end else if (ce_in) begin
			ack_ff <= wb_cyc_in && wb_stb_in && !ack_ff;
		end
	end

	// configuration writes; status words are read-only
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_ff <= `CTRL_RST;
			top_ff <= `TOP_RST;
			aper_base_ff <= `BASE_RST;
			aper_mask_ff <= `MASK_RST;
			mmio_base_ff <= `BASE_RST;
			mmio_mask_ff <= `MASK_RST;
		end else if (ce_in && wr_stb) begin
			unique case (wb_adr_in)
				`REG_CTRL: begin
					ctrl_ff <= merge(ctrl_ff, wb_dat_in, wb_sel_in) & `CTRL_WMASK;
				end
				`REG_TOP: begin
					top_ff <= merge(top_ff, wb_dat_in, wb_sel_in);
				end
				`REG_APER_BASE: begin
					aper_base_ff <= merge(aper_base_ff, wb_dat_in, wb_sel_in);
				end
				`REG_APER_MASK: begin
					aper_mask_ff <= merge(aper_mask_ff, wb_dat_in, wb_sel_in);
				end
				`REG_MMIO_BASE: begin
					mmio_base_ff <= merge(mmio_base_ff, wb_dat_in, wb_sel_in);
				end
				`REG_MMIO_MASK: begin
					mmio_mask_ff <= merge(mmio_mask_ff, wb_dat_in, wb_sel_in);
				end
				default: begin
					// unmapped or read-only: write ignored
				end
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		unique case (wb_adr_in)
			`REG_CTRL: nxt_rdat = ctrl_ff;
			`REG_TOP: nxt_rdat = top_eff;
			`REG_APER_BASE: nxt_rdat = aper_base_ff;
			`REG_APER_MASK: nxt_rdat = aper_mask_ff;
			`REG_MMIO_BASE: nxt_rdat = mmio_base_ff;
			`REG_MMIO_MASK: nxt_rdat = mmio_mask_ff;
			`REG_USABLE: nxt_rdat = usable_top;
			`REG_LAST: nxt_rdat = {24'h000000, unit_ff, 2'h0, dest_ff};
			default: nxt_rdat = `ZERO32;
		endcase
	end

	// read data held with the answer
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdat_ff <= `ZERO32;
		end else if (ce_in && wb_cyc_in && wb_stb_in && !ack_ff) begin
			rdat_ff <= nxt_rdat;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign wb_ack_out = ack_ff;
	assign wb_dat_out = rdat_ff;
	assign dest_valid_out = valid_ff;
	assign dest_sel_out = dest_ff;
	assign dest_addr_out = daddr_ff;
	assign discard_write_out = discard_ff;
	assign zero_read_out = zero_ff;
	assign apic_unit_out = unit_ff;

	// ***************************************************
	// checks
	// ***************************************************
	sequence s_take;
		ce_in && req_valid_in;
	endsequence
	sequence s_high_mgmt_segment_cpu;
		s_take ##0 (req_addr_in[31:17] == `HIGH_MGMT_SEGMENT_TAG) && ctrl_ff[`CTRL_HIGH_MGMT_SEGMENT_BIT] &&
			(req_src_in == xmem_pkg::SRC_CPU);
	endsequence

	property p_main_dram;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_take ##0 (req_addr_in >= `ONE_MB) && (req_addr_in < top_mgmt_segment_base) &&
			!(ctrl_ff[`CTRL_HOLE_BIT] && (req_addr_in[31:20] == `HOLE_TAG))
		|=> (dest_sel_out == xmem_pkg::DEST_DRAM) && (dest_addr_out == $past(req_addr_in));
	endproperty
	a_main_dram: assert property (p_main_dram) else $error("main memory not to dram");

	property p_top_cap;
		@(posedge clk_in) disable iff (!rst_n_in)
		top_eff <= `TOP_MAX;
	endproperty
	a_top_cap: assert property (p_top_cap) else $error("top of memory over ceiling");

	property p_hole_hub;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_take ##0 ctrl_ff[`CTRL_HOLE_BIT] && (req_addr_in[31:20] == `HOLE_TAG)
		|=> (dest_sel_out == xmem_pkg::DEST_HUB) && (dest_addr_out == $past(req_addr_in));
	endproperty
	a_hole_hub: assert property (p_hole_hub) else $error("hole not sent to hub");

	property p_high_mgmt_segment_smm;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_high_mgmt_segment_cpu ##0 req_smm_in
		|=> (dest_sel_out == xmem_pkg::DEST_DRAM) &&
			(dest_addr_out == {`HIGH_MGMT_SEGMENT_DRAM_TAG, $past(req_addr_in[16:0])});
	endproperty
	a_high_mgmt_segment_smm: assert property (p_high_mgmt_segment_smm) else $error("high segment remap wrong");

	property p_high_mgmt_segment_plain;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_high_mgmt_segment_cpu ##0 !req_smm_in && !req_wb_in
		|=> dest_valid_out && (dest_sel_out == xmem_pkg::DEST_ABORT);
	endproperty
	a_high_mgmt_segment_plain: assert property (p_high_mgmt_segment_plain) else $error("plain high access not aborted");

	property p_hub_smm;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_take ##0 (req_src_in == xmem_pkg::SRC_HUB) && (dif.hit_high_mgmt_segment || dif.hit_top_mgmt_segment)
		|=> (dest_sel_out == xmem_pkg::DEST_ABORT);
	endproperty
	a_hub_smm: assert property (p_hub_smm) else $error("hub reached smm space");

	property p_bios_hub;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_take ##0 (req_addr_in[31:21] == `BIOS_TAG) |=> (dest_sel_out == xmem_pkg::DEST_HUB);
	endproperty
	a_bios_hub: assert property (p_bios_hub) else $error("boot region not to hub");

	property p_zero_read;
		@(posedge clk_in) disable iff (!rst_n_in)
		ce_in ##1 dest_valid_out && (dest_sel_out == xmem_pkg::DEST_ABORT)
		|-> (discard_write_out != zero_read_out) && (zero_read_out == !$past(req_write_in));
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("invalid access answer wrong");

	property p_ack_pulse;
		@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && wb_ack_out |=> !wb_ack_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule

// [tb/req_source.sv]
// Purpose: requester model for the processor bus and the hub link
// Assumes: one request per issue call, launched just after a rising edge
// Notes: released lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
module req_source (
	input wire logic clk_in,
	output logic req_valid_out,
	output logic [31:0] req_addr_out,
	output logic req_smm_out,
	output logic req_src_out,
	output logic req_wb_out,
	output logic req_write_out
);
	// ************************
	// request launcher
	// ************************
	// idle at time zero, no request before reset is released
	initial begin
		req_valid_out = 1'b0;
		req_addr_out = 32'h00000000;
		{req_smm_out, req_src_out, req_wb_out, req_write_out} = 4'h0;
	end
	// kind is {smm, source, write-back, write}; one cycle each
	task automatic issue(input logic [31:0] addr, input logic [3:0] kind);
		@(posedge clk_in);
		req_valid_out <= 1'b1;
		req_addr_out <= addr;
		{req_smm_out, req_src_out, req_wb_out, req_write_out} <= kind;
		@(posedge clk_in);
		// inverse pattern so a decoder that samples late sees garbage
		req_valid_out <= 1'b0;
		req_addr_out <= ~addr;
		{req_smm_out, req_src_out, req_wb_out, req_write_out} <= ~kind;
	endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the extended memory address decoder
// Assumes: one 200 MHz clock, registers over classic wishbone
// Notes: table rows first, then a second reset and corner cases
`timescale 1ns/10ps
`include "xmem_defines.svh"
module tb_top;
	// ************************
	// signals and table
	// ************************
	logic clk_in = 1'b0; // 5 ns period
	logic rst_n_in = 1'b0; // held low for four cycles
	logic ce_in = 1'b1;
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'hF; // whole words only
	logic [31:0] wb_dat_in = 32'h00000000;
	logic [31:0] wb_dat_out, dest_addr_out, rd, req_addr_in;
	logic wb_ack_out, dest_valid_out, discard_write_out, zero_read_out;
	logic req_valid_in, req_smm_in, req_src_in, req_wb_in, req_write_in;
	logic [1:0] dest_sel_out;
	logic [3:0] apic_unit_out;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int i;
	typedef struct {logic [31:0] a; logic [3:0] k; xmem_pkg::dest_t d; logic [31:0] da;
		logic [3:0] ap;} row_t;
	// kind {smm, src, wb, write}; top 512 MB, top segment 1 MB, all windows on
	row_t rows [18] = '{
		'{32'h00200000, 4'h0, xmem_pkg::DEST_DRAM, 32'h00200000, 4'h0},
		'{32'h00F00010, 4'h0, xmem_pkg::DEST_HUB, 32'h00F00010, 4'h0},
		'{32'h1FFFFFFC, 4'h0, xmem_pkg::DEST_ABORT, 32'h00000000, 4'h0},
		'{32'h1FF00000, 4'h8, xmem_pkg::DEST_DRAM, 32'h1FF00000, 4'h0},
		'{32'h1FF00000, 4'h3, xmem_pkg::DEST_DRAM, 32'h1FF00000, 4'h0},
		'{32'hFEDA1234, 4'h8, xmem_pkg::DEST_DRAM, 32'h000A1234, 4'h0},
		'{32'hFEDB0000, 4'h0, xmem_pkg::DEST_ABORT, 32'h00000000, 4'h0},
		'{32'hFEDB0004, 4'h3, xmem_pkg::DEST_DRAM, 32'h000B0004, 4'h0},
		'{32'hFEDA0000, 4'h5, xmem_pkg::DEST_ABORT, 32'h00000000, 4'h0},
		'{32'h1FF00010, 4'hC, xmem_pkg::DEST_ABORT, 32'h00000000, 4'h0},
		'{32'h20000000, 4'h0, xmem_pkg::DEST_HUB, 32'h20000000, 4'h0},
		'{32'hD0001000, 4'h0, xmem_pkg::DEST_GFX, 32'hD0001000, 4'h0},
		'{32'hE0040000, 4'h1, xmem_pkg::DEST_GFX, 32'hE0040000, 4'h0},
		'{32'hFEC03000, 4'h0, xmem_pkg::DEST_HUB, 32'hFEC03000, 4'h3},
		'{32'hFEE05000, 4'h1, xmem_pkg::DEST_HUB, 32'hFEE05000, 4'h5},
		'{32'hFED00000, 4'h0, xmem_pkg::DEST_HUB, 32'hFED00000, 4'h5},
		'{32'hFFE00000, 4'h0, xmem_pkg::DEST_HUB, 32'hFFE00000, 4'h5},
		'{32'hFFFFFFF0, 4'h4, xmem_pkg::DEST_HUB, 32'hFFFFFFF0, 4'h5}
	};
	logic [7:0] regs [7] = '{`REG_CTRL, `REG_TOP, `REG_APER_BASE, `REG_APER_MASK,
		`REG_MMIO_BASE, `REG_MMIO_MASK, `REG_USABLE};
	logic [31:0] rvals [7] = '{`CTRL_RST, `TOP_RST, `BASE_RST, `MASK_RST, `BASE_RST,
		`MASK_RST, `TOP_RST};

	always #2.5 clk_in = ~clk_in;

	// hang guard, the full run needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end

	extended_memory_address_decoder u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.ce_in(ce_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .req_valid_in(req_valid_in),
		.req_addr_in(req_addr_in), .req_smm_in(req_smm_in), .req_src_in(req_src_in),
		.req_wb_in(req_wb_in), .req_write_in(req_write_in),
		.dest_valid_out(dest_valid_out), .dest_sel_out(dest_sel_out),
		.dest_addr_out(dest_addr_out), .discard_write_out(discard_write_out),
		.zero_read_out(zero_read_out), .apic_unit_out(apic_unit_out));
	req_source u_req (.clk_in(clk_in), .req_valid_out(req_valid_in),
		.req_addr_out(req_addr_in), .req_smm_out(req_smm_in), .req_src_out(req_src_in),
		.req_wb_out(req_wb_in), .req_write_out(req_write_in));

	// ************************
	// tasks
	// ************************
	task automatic wrap_up();
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_dest(input xmem_pkg::dest_t exp, input logic [1:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected dest expected %h seen %h", exp, got);
		end
	endtask
	// one classic cycle; waits for ack, never assumes its latency
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] q);
		int n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= adr;
		wb_dat_in <= dat;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 20);
		// a late answer on the last try still counts as an answer
		if (wb_ack_out !== 1'b1) begin
			errors++;
			$display("unexpected ack expected 1 seen %b", wb_ack_out);
		end
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	// answer is registered, so it is looked at just after the next edge
	task automatic send(input logic [31:0] a, input logic [3:0] k, input xmem_pkg::dest_t d,
		input logic [31:0] da);
		u_req.issue(a, k);
		#1;
		chk_word("valid", 32'h00000001, {31'h00000000, dest_valid_out});
		chk_dest(d, dest_sel_out);
		if (d != xmem_pkg::DEST_ABORT) begin
			chk_word("addr", da, dest_addr_out);
		end
		chk_word("discard", {31'h00000000, d == xmem_pkg::DEST_ABORT && k[0]},
			{31'h00000000, discard_write_out});
		chk_word("zero", {31'h00000000, d == xmem_pkg::DEST_ABORT && !k[0]},
			{31'h00000000, zero_read_out});
	endtask

	// ************************
	// main sequence
	// ************************
	initial begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		wb_cycle(1'b1, `REG_CTRL, 32'h0000000F, rd);
		wb_cycle(1'b1, `REG_TOP, 32'h30000000, rd);
		wb_cycle(1'b0, `REG_TOP, 32'h00000000, rd);
		chk_word("top", 32'h20000000, rd);
		wb_cycle(1'b0, `REG_USABLE, 32'h00000000, rd);
		chk_word("usable", 32'h1FF00000, rd);
		// graphics windows kept clear of the apic and bios ranges
		wb_cycle(1'b1, `REG_APER_BASE, 32'hD0000000, rd);
		wb_cycle(1'b1, `REG_APER_MASK, 32'hF0000000, rd);
		wb_cycle(1'b1, `REG_MMIO_BASE, 32'hE0000000, rd);
		wb_cycle(1'b1, `REG_MMIO_MASK, 32'hFFF80000, rd);
		for (i = 0; i < 18; i++) begin
			send(rows[i].a, rows[i].k, rows[i].d, rows[i].da);
			chk_word("apic", {28'h0000000, rows[i].ap}, {28'h0000000, apic_unit_out});
		end
		// second reset in mid-run, then reset values
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk_dest(xmem_pkg::DEST_HUB, dest_sel_out);
		chk_word("apic", 32'h00000000, {28'h0000000, apic_unit_out});
		for (i = 0; i < 7; i++) begin
			wb_cycle(1'b0, regs[i], 32'h00000000, rd);
			chk_word("reg", rvals[i], rd);
		end
		// read-only usable top ignores writes; unmapped reads give zero
		wb_cycle(1'b1, `REG_USABLE, 32'h12300000, rd);
		wb_cycle(1'b0, `REG_USABLE, 32'h00000000, rd);
		chk_word("usable", `TOP_RST, rd);
		wb_cycle(1'b0, 8'h20, 32'h00000000, rd);
		chk_word("unmapped", 32'h00000000, rd);
		// all windows off: hole memory reachable, high segment falls to hub
		send(32'h00F00000, 4'h0, xmem_pkg::DEST_DRAM, 32'h00F00000);
		send(32'hFEDA0000, 4'h0, xmem_pkg::DEST_HUB, 32'hFEDA0000);
		// 8 MB top segment at the top of 64 MB
		wb_cycle(1'b1, `REG_CTRL, 32'h00000034, rd);
		wb_cycle(1'b0, `REG_USABLE, 32'h00000000, rd);
		chk_word("usable", 32'h03800000, rd);
		send(32'h03800000, 4'h0, xmem_pkg::DEST_ABORT, 32'h00000000);
		send(32'h037FFFFC, 4'h1, xmem_pkg::DEST_DRAM, 32'h037FFFFC);
		send(32'h03FFFFFC, 4'h8, xmem_pkg::DEST_DRAM, 32'h03FFFFFC);
		// clock enable low: a request is ignored and the last result holds
		@(posedge clk_in);
		ce_in <= 1'b0;
		u_req.issue(32'h20000000, 4'h0);
		#1;
		chk_word("frozen valid", 32'h00000000, {31'h00000000, dest_valid_out});
		chk_dest(xmem_pkg::DEST_DRAM, dest_sel_out);
		chk_word("frozen addr", 32'h03FFFFFC, dest_addr_out);
		// enable back on: the same request now decodes to the hub
		@(posedge clk_in);
		ce_in <= 1'b1;
		send(32'h20000000, 4'h0, xmem_pkg::DEST_HUB, 32'h20000000);
		wrap_up();
	end
endmodule
